// *** rtl/srg_sequencer.sv ***
// Regulator startup, shutdown, power-good and mode control
`timescale 1ns/10ps
`include "srg_defines.svh"
module srg_sequencer #(
  parameter int INIT_CYC = `SRG_INIT_CYC,
  parameter int OFF_CYC  = `SRG_OFF_CYC
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               output_enable_pin,
  input  wire srg_pkg::srg_pins_t pins_async,
  input  wire logic               set_voltage_core,
  input  wire logic               set_voltage_aux,
  input  wire logic               boot_zero_core,
  input  wire logic               boot_zero_aux,
  input  wire logic [1:0]         scenario_ontime_sel,
  input  wire logic [3:0]         aps_phase_count,
  input  wire logic               ps_single_phase,
  input  wire logic               auto_dcm,
  input  wire srg_pkg::srg_telem_t telem,
  input  wire logic               reg_wr_en,
  input  wire logic               reg_rd_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic [15:0]             reg_rdata,
  output logic                    core_power_good,
  output logic                    aux_power_good,
  output logic                    vid_bus_active,
  output logic                    stage_detect_start,
  output logic                    core_regulate,
  output logic                    aux_regulate,
  output logic                    ramp_slow,
  output logic                    fault_flag,
  output logic                    bias_hs_on,
  output logic                    bias_ls_on,
  output logic                    dcm_mode,
  output logic [3:0]              active_phases,
  output logic                    dcm_offset_low,
  output logic [2:0]              input_sense_range_select,
  output logic [6:0]              input_current_full_scale,
  output logic [15:0]             vid_input_power
);
  localparam int NP = $bits(srg_pkg::srg_pins_t);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NP-1:0]      sync1;
  logic [NP-1:0]      sync2;
  srg_pkg::srg_pins_t syn;
  logic               enable_f;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins_async[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate
  assign syn = srg_pkg::srg_pins_t'(sync2);

  srg_deglitch #(
    .CNT (`SRG_DEGLITCH_CYC)
  ) u_enable_filter (
    .clk    (clk),
    .resetn (resetn),
    .raw    (output_enable_pin),
    .filt   (enable_f)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  dcm_offset_config;
  logic [15:0] input_sense_config;
  logic [7:0]  bias_reg_ontime_config;
  logic [7:0]  input_full_scale_config;
  logic        ontime_override;
  logic [7:0]  status_monitor;

  wire hit_dcm  = reg_addr == `SRG_ADDR_DCM_OFFSET;
  wire hit_sns  = reg_addr == `SRG_ADDR_IN_SENSE;
  wire hit_ont  = reg_addr == `SRG_ADDR_BIAS_ONT;
  wire hit_fs   = reg_addr == `SRG_ADDR_IN_FS;
  wire hit_st   = reg_addr == `SRG_ADDR_STATUS;
  wire hit_vin  = reg_addr == `SRG_ADDR_VIN;
  wire hit_iin  = reg_addr == `SRG_ADDR_IIN;
  wire hit_pin  = reg_addr == `SRG_ADDR_PIN;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dcm_offset_config       <= `SRG_RST_DCM_OFFSET;
      input_sense_config      <= `SRG_RST_IN_SENSE;
      bias_reg_ontime_config  <= `SRG_RST_BIAS_ONT;
      input_full_scale_config <= `SRG_RST_IN_FS;
      ontime_override         <= 1'b0;
    end else if (reg_wr_en) begin
      if (hit_dcm) dcm_offset_config <= reg_wdata[7:0];
      if (hit_sns) input_sense_config <= reg_wdata;
      if (hit_fs) input_full_scale_config <= reg_wdata[7:0];
      if (hit_ont) begin
        bias_reg_ontime_config <= reg_wdata[7:0];
        ontime_override        <= 1'b1;
      end
    end
  end

  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    unique case (1'b1)
      hit_dcm: next_rdata = {8'h00, dcm_offset_config};
      hit_sns: next_rdata = input_sense_config;
      hit_ont: next_rdata = {8'h00, bias_reg_ontime_config};
      hit_fs:  next_rdata = {8'h00, input_full_scale_config};
      hit_st:  next_rdata = {8'h00, status_monitor};
      hit_vin: next_rdata = telem.vin;
      hit_iin: next_rdata = telem.iin;
      hit_pin: next_rdata = telem.pin;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd_en) begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Startup state machine
  // ---------------------------------------------------------------
  srg_pkg::srg_state_t state;
  logic [31:0]         tmr;
  logic                core_vid_seen;
  logic                aux_vid_seen;

  wire bias_good  = syn.avdd_ok && syn.dvdd_ok && syn.vdd3p3_ok;
  wire start_ok   = syn.vin_ok && syn.stage_bias_ok;
  wire tmr_done   = tmr == 32'h0000_0000;
  wire init_bad   = !syn.cfg_valid || syn.sense_open;
  wire stop_req   = !enable_f || !start_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= srg_pkg::SRG_BIAS_WAIT;
      tmr   <= 32'h0000_0000;
    end else if (!bias_good) begin
      state <= srg_pkg::SRG_BIAS_WAIT;
      tmr   <= 32'h0000_0000;
    end else begin
      if (!tmr_done) tmr <= tmr - 32'h0000_0001;
      unique case (state)
        srg_pkg::SRG_BIAS_WAIT: begin
          state <= srg_pkg::SRG_INIT;
          tmr   <= 32'(INIT_CYC - 1);
        end
        srg_pkg::SRG_INIT: begin
          if (tmr_done) begin
            state <= init_bad ? srg_pkg::SRG_FAULT : srg_pkg::SRG_READY;
          end
        end
        srg_pkg::SRG_FAULT: begin
          state <= srg_pkg::SRG_FAULT;
        end
        srg_pkg::SRG_READY: begin
          // Enable may already be high; no ordering is demanded
          if (enable_f && start_ok) begin
            state <= srg_pkg::SRG_DETECT;
          end
        end
        srg_pkg::SRG_DETECT: begin
          if (syn.stage_fault) begin
            state <= srg_pkg::SRG_FAULT;
          end else if (stop_req) begin
            state <= srg_pkg::SRG_OFF_WAIT;
            tmr   <= 32'(OFF_CYC - 1);
          end else if (syn.detect_done) begin
            state <= srg_pkg::SRG_RUN;
          end
        end
        srg_pkg::SRG_RUN: begin
          if (stop_req) begin
            state <= srg_pkg::SRG_OFF_WAIT;
            tmr   <= 32'(OFF_CYC - 1);
          end
        end
        srg_pkg::SRG_OFF_WAIT: begin
          if (tmr_done) begin
            state <= srg_pkg::SRG_READY;
          end
        end
      endcase
    end
  end

  // Fault log survives until the bias supplies collapse and init reruns
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_monitor <= 8'h00;
    end else if (state == srg_pkg::SRG_BIAS_WAIT) begin
      status_monitor <= 8'h00;
    end else begin
      if (state == srg_pkg::SRG_INIT && tmr_done) begin
        status_monitor[`SRG_ST_CFG_BIT]  <= !syn.cfg_valid;
        status_monitor[`SRG_ST_OPEN_BIT] <= syn.sense_open;
      end
      if (state == srg_pkg::SRG_DETECT && syn.stage_fault) begin
        status_monitor[`SRG_ST_STAGE_BIT] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Rail start and power good
  // ---------------------------------------------------------------
  wire in_run    = state == srg_pkg::SRG_RUN;
  wire core_go   = syn.core_sense_low && (!boot_zero_core || core_vid_seen);
  wire aux_go    = syn.aux_sense_low && (!boot_zero_aux || aux_vid_seen);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_vid_seen <= 1'b0;
      aux_vid_seen  <= 1'b0;
    end else if (!in_run) begin
      core_vid_seen <= 1'b0;
      aux_vid_seen  <= 1'b0;
    end else begin
      if (set_voltage_core) core_vid_seen <= 1'b1;
      if (set_voltage_aux) aux_vid_seen <= 1'b1;
    end
  end

  // Rails latch on independently; a rail already up ignores its sense
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_regulate <= 1'b0;
      aux_regulate  <= 1'b0;
    end else if (!in_run) begin
      core_regulate <= 1'b0;
      aux_regulate  <= 1'b0;
    end else begin
      if (core_go) core_regulate <= 1'b1;
      if (aux_go) aux_regulate <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_power_good    <= 1'b0;
      aux_power_good     <= 1'b0;
      vid_bus_active     <= 1'b0;
      stage_detect_start <= 1'b0;
      ramp_slow          <= 1'b0;
      fault_flag         <= 1'b0;
    end else begin
      core_power_good    <= in_run && core_regulate && syn.core_at_target;
      aux_power_good     <= in_run && aux_regulate && syn.aux_at_target;
      vid_bus_active     <= in_run || state == srg_pkg::SRG_DETECT;
      stage_detect_start <= state == srg_pkg::SRG_DETECT;
      ramp_slow          <= in_run && !(core_power_good && aux_power_good);
      fault_flag         <= state == srg_pkg::SRG_FAULT;
    end
  end

  // ---------------------------------------------------------------
  // Conduction mode and input sensing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dcm_mode                 <= 1'b0;
      active_phases            <= 4'h0;
      dcm_offset_low           <= 1'b0;
      input_sense_range_select <= 3'h0;
      input_current_full_scale <= 7'h00;
      vid_input_power          <= 16'h0000;
    end else begin
      dcm_mode       <= auto_dcm && ps_single_phase;
      active_phases  <= (auto_dcm && ps_single_phase) ? 4'h1 : aps_phase_count;
      dcm_offset_low <= dcm_offset_config[`SRG_DCM_OFFSET_BIT];
      input_sense_range_select <=
        input_sense_config[`SRG_SENSE_SEL_HI:`SRG_SENSE_SEL_LO];
      input_current_full_scale <=
        input_full_scale_config[`SRG_FS_HI:`SRG_FS_LO];
      vid_input_power <= telem.pin;
    end
  end

  // ---------------------------------------------------------------
  // Bias regulator
  // ---------------------------------------------------------------
  logic [1:0]  ont_sel;
  logic [11:0] ontime_cyc;
  assign ont_sel = ontime_override ?
                   bias_reg_ontime_config[`SRG_ONT_HI:`SRG_ONT_LO] : scenario_ontime_sel;

  always_comb begin
    ontime_cyc = 12'h000;
    unique case (ont_sel)
      2'h0: ontime_cyc = 12'(`SRG_ONTIME0_NS * `SRG_CLK_MHZ / 1000);
      2'h1: ontime_cyc = 12'(`SRG_ONTIME1_NS * `SRG_CLK_MHZ / 1000);
      2'h2: ontime_cyc = 12'(`SRG_ONTIME2_NS * `SRG_CLK_MHZ / 1000);
      2'h3: ontime_cyc = 12'(`SRG_ONTIME3_NS * `SRG_CLK_MHZ / 1000);
    endcase
  end

  srg_bias_cot u_bias_cot (
    .clk        (clk),
    .resetn     (resetn),
    .below_ref  (syn.bias_below_ref),
    .ind_zero   (syn.ind_zero),
    .ontime_cyc (ontime_cyc),
    .hs_on      (bias_hs_on),
    .ls_on      (bias_ls_on)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_init_runs_full: assert property (@(posedge clk) disable iff (!resetn)
    (state == srg_pkg::SRG_INIT && !tmr_done && bias_good) |=> state == srg_pkg::SRG_INIT)
    else $error("initialization left early");
  a_enable_gated: assert property (@(posedge clk) disable iff (!resetn)
    (state == srg_pkg::SRG_READY && !start_ok) |=> state != srg_pkg::SRG_DETECT)
    else $error("enable taken without input and bias good");
  a_run_after_detect: assert property (@(posedge clk) disable iff (!resetn)
    $rose(in_run) |-> $past(state == srg_pkg::SRG_DETECT && syn.detect_done))
    else $error("ramp began without completed detection");
  a_pg_own_rail: assert property (@(posedge clk) disable iff (!resetn)
    core_power_good |-> $past(core_regulate && syn.core_at_target))
    else $error("core power good without its rail at target");
  a_boot_zero_wait: assert property (@(posedge clk) disable iff (!resetn)
    ($rose(aux_regulate) && $past(boot_zero_aux)) |-> $past(aux_vid_seen))
    else $error("rail without boot voltage started unprompted");
  a_restart_blocked: assert property (@(posedge clk) disable iff (!resetn)
    (state == srg_pkg::SRG_OFF_WAIT && !tmr_done && bias_good)
      |=> state == srg_pkg::SRG_OFF_WAIT)
    else $error("restart before minimum off time");
  a_sense_low_start: assert property (@(posedge clk) disable iff (!resetn)
    $rose(core_regulate) |-> $past(syn.core_sense_low))
    else $error("core started with high remote sense");
  a_dcm_single: assert property (@(posedge clk) disable iff (!resetn)
    dcm_mode |-> active_phases == 4'h1)
    else $error("discontinuous mode with several phases");
  a_fault_blocks: assert property (@(posedge clk) disable iff (!resetn)
    fault_flag |-> !core_regulate && !aux_regulate)
    else $error("regulation while fault flagged");
  a_pg_low_idle: assert property (@(posedge clk) disable iff (!resetn)
    (state != srg_pkg::SRG_RUN) |=> !core_power_good && !aux_power_good)
    else $error("power good outside regulation");

  c_startup: cover property (@(posedge clk) disable iff (!resetn)
    $rose(core_power_good));
  c_restart: cover property (@(posedge clk) disable iff (!resetn)
    state == srg_pkg::SRG_OFF_WAIT ##1 state == srg_pkg::SRG_READY);
  c_fault: cover property (@(posedge clk) disable iff (!resetn)
    $rose(fault_flag));
  c_bias_pulse: cover property (@(posedge clk) disable iff (!resetn)
    $rose(bias_hs_on));
endmodule

// *** shared/srg_defines.svh ***
// Offsets, field positions, reset values and timing counts of the startup sequencer
`ifndef SRG_DEFINES_SVH
`define SRG_DEFINES_SVH

`define SRG_CLK_MHZ         200
`define SRG_INIT_TIME_US    800
`define SRG_OFF_TIME_US     200
`define SRG_DEGLITCH_NS     200
`define SRG_INIT_CYC        (`SRG_INIT_TIME_US * `SRG_CLK_MHZ)
`define SRG_OFF_CYC         (`SRG_OFF_TIME_US * `SRG_CLK_MHZ)
`define SRG_DEGLITCH_CYC    (`SRG_DEGLITCH_NS * `SRG_CLK_MHZ / 1000)

`define SRG_ONTIME0_NS      575
`define SRG_ONTIME1_NS      1150
`define SRG_ONTIME2_NS      1725
`define SRG_ONTIME3_NS      2300

`define SRG_ADDR_DCM_OFFSET 8'hB3
`define SRG_ADDR_IN_SENSE   8'hD4
`define SRG_ADDR_BIAS_ONT   8'hD6
`define SRG_ADDR_IN_FS      8'hDE
`define SRG_ADDR_STATUS     8'hF9
`define SRG_ADDR_VIN        8'h88
`define SRG_ADDR_IIN        8'h89
`define SRG_ADDR_PIN        8'h97

`define SRG_DCM_OFFSET_BIT  6
`define SRG_SENSE_SEL_HI    15
`define SRG_SENSE_SEL_LO    13
`define SRG_ONT_HI          7
`define SRG_ONT_LO          6
`define SRG_FS_HI           6
`define SRG_FS_LO           0

`define SRG_ST_CFG_BIT      0
`define SRG_ST_OPEN_BIT     1
`define SRG_ST_STAGE_BIT    2

`define SRG_RST_DCM_OFFSET  8'h00
`define SRG_RST_IN_SENSE    16'h0000
`define SRG_RST_BIAS_ONT    8'h00
`define SRG_RST_IN_FS       8'h00

`endif

// *** shared/srg_pkg.sv ***
// Types shared by the startup sequencer modules
package srg_pkg;

  typedef enum logic [2:0] {
    SRG_BIAS_WAIT,
    SRG_INIT,
    SRG_FAULT,
    SRG_READY,
    SRG_DETECT,
    SRG_RUN,
    SRG_OFF_WAIT
  } srg_state_t;

  typedef struct packed {
    logic avdd_ok;
    logic dvdd_ok;
    logic vdd3p3_ok;
    logic vin_ok;
    logic stage_bias_ok;
    logic cfg_valid;
    logic sense_open;
    logic core_sense_low;
    logic aux_sense_low;
    logic detect_done;
    logic stage_fault;
    logic core_at_target;
    logic aux_at_target;
    logic bias_below_ref;
    logic ind_zero;
  } srg_pins_t;

  typedef struct packed {
    logic [15:0] iin;
    logic [15:0] vin;
    logic [15:0] pin;
  } srg_telem_t;

endpackage

// *** rtl/srg_deglitch.sv ***
// Enable pin synchroniser with low-pulse deglitch filter
`timescale 1ns/10ps
`include "srg_defines.svh"
module srg_deglitch #(
  parameter int CNT = `SRG_DEGLITCH_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic raw,
  output logic      filt
);
  logic        s1;
  logic        s2;
  logic [15:0] low_cnt;
  wire         low_done = (low_cnt == 16'(CNT - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  // Rising edge passes at once; a fall must persist to count as disable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 16'h0000;
      filt    <= 1'b0;
    end else if (s2) begin
      low_cnt <= 16'h0000;
      filt    <= 1'b1;
    end else if (filt) begin
      low_cnt <= low_done ? 16'h0000 : low_cnt + 16'h0001;
      if (low_done) begin
        filt <= 1'b0;
      end
    end
  end

  a_short_low_ignored: assert property (@(posedge clk) disable iff (!resetn)
    $fell(filt) |-> $past(!s2, CNT))
    else $error("enable dropped before deglitch time");
endmodule

// *** rtl/srg_bias_cot.sv ***
// Constant on-time controller for the integrated bias regulator
`timescale 1ns/10ps
module srg_bias_cot (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        below_ref,
  input  wire logic        ind_zero,
  input  wire logic [11:0] ontime_cyc,
  output logic             hs_on,
  output logic             ls_on
);
  typedef enum logic [1:0] {SRG_COT_IDLE, SRG_COT_HS, SRG_COT_LS} srg_cot_t;
  srg_cot_t    state;
  logic [11:0] cnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SRG_COT_IDLE;
      cnt   <= 12'h000;
    end else begin
      unique case (state)
        SRG_COT_IDLE: begin
          // New pulse only from zero inductor current limits average current
          if (below_ref && ind_zero) begin
            state <= SRG_COT_HS;
            cnt   <= ontime_cyc;
          end
        end
        SRG_COT_HS: begin
          cnt <= cnt - 12'h001;
          if (cnt <= 12'h001) begin
            state <= SRG_COT_LS;
          end
        end
        SRG_COT_LS: begin
          if (ind_zero) begin
            state <= SRG_COT_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_on <= 1'b0;
      ls_on <= 1'b0;
    end else begin
      hs_on <= (state == SRG_COT_IDLE) ? (below_ref && ind_zero) : (state == SRG_COT_HS
               && cnt > 12'h001);
      ls_on <= (state == SRG_COT_HS && cnt <= 12'h001) || (state == SRG_COT_LS && !ind_zero);
    end
  end

  a_hs_from_zero: assert property (@(posedge clk) disable iff (!resetn)
    $rose(hs_on) |-> $past(ind_zero))
    else $error("bias high side started with inductor current");
  a_ls_follows_hs: assert property (@(posedge clk) disable iff (!resetn)
    $fell(hs_on) |-> ls_on)
    else $error("low side did not follow high side pulse");
endmodule

// *** testbench/srg_host.sv ***
// Host model driving the enable pin and the supply rails
`timescale 1ns/10ps
module srg_host (
  input  wire logic       clk,
  input  wire logic       power,
  input  wire logic       en_req,
  output logic            en,
  output logic [4:0]      rails
);
  logic [5:0] low_cnt;
  initial begin
    en = 1'b0;
    rails = 5'h00;
    low_cnt = 6'h00;
  end
  // ----------------------------------------------------------------
  // Enable first, rails later, so the outputs ramp down under control
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    en <= en_req && power;
    low_cnt <= en ? 6'h00 : (low_cnt == 6'h3F ? low_cnt : low_cnt + 6'h01);
    if (power) rails <= 5'h1F;
    else if (!en && low_cnt == 6'h3F) rails <= 5'h00;
  end
endmodule

// *** testbench/tb_srg_sequencer.sv ***
// Self-checking bench of the startup sequencer
`timescale 1ns/10ps
module tb_srg_sequencer;
  logic clk = 1'b0, resetn = 1'b0, power = 1'b0, en_req = 1'b0, output_enable_pin;
  logic [4:0] rails;
  logic [9:0] tp = 10'h200;
  srg_pkg::srg_pins_t pins_async;
  srg_pkg::srg_telem_t telem = 48'h0;
  logic set_voltage_core = 0, set_voltage_aux = 0, boot_zero_core = 0, boot_zero_aux = 0;
  logic ps_single_phase = 0, auto_dcm = 0, reg_wr_en = 0, reg_rd_en = 0;
  logic [1:0] scenario_ontime_sel = 2'h0;
  logic [3:0] aps_phase_count = 4'h4, active_phases;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, vid_input_power, d;
  logic core_power_good, aux_power_good, vid_bus_active, stage_detect_start, core_regulate;
  logic aux_regulate, ramp_slow, fault_flag, bias_hs_on, bias_ls_on, dcm_mode, dcm_offset_low;
  logic [2:0] input_sense_range_select;
  logic [6:0] input_current_full_scale;
  logic [31:0] seed = 32'h0b4252b0;
  logic [15:0] v [4];
  int fails = 0, tests_run = 0, n;
  assign pins_async = {rails, tp};
  always #2.5 clk = ~clk;
  srg_host host (.clk, .power, .en_req, .en(output_enable_pin), .rails);
  srg_sequencer #(.INIT_CYC(50), .OFF_CYC(30)) dut (.clk, .resetn, .output_enable_pin,
    .pins_async, .set_voltage_core, .set_voltage_aux, .boot_zero_core, .boot_zero_aux,
    .scenario_ontime_sel, .aps_phase_count, .ps_single_phase, .auto_dcm, .telem, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .core_power_good, .aux_power_good,
    .vid_bus_active, .stage_detect_start, .core_regulate, .aux_regulate, .ramp_slow,
    .fault_flag, .bias_hs_on, .bias_ls_on, .dcm_mode, .active_phases, .dcm_offset_low,
    .input_sense_range_select, .input_current_full_scale, .vid_input_power);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = w;
    cyc(1);
    reg_wr_en = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd_en = 1;
    reg_addr = a;
    cyc(1);
    reg_rd_en = 0;
    d = reg_rdata;
    cyc(1);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    test_done();
  end
  initial begin
    cyc(20);
    resetn = 1;
    chk({core_power_good, aux_power_good, fault_flag, stage_detect_start}, 0);
    foreach (v[i]) begin
      rd(i[1] ? (i[0] ? 8'hDE : 8'hD6) : (i[0] ? 8'hD4 : 8'hB3));
      chk(d, 0);
      v[i] = 16'(xs());
      if (i != 1) v[i] &= 16'h00FF;
      wr(reg_addr, v[i]);
      rd(reg_addr);
      chk(d, v[i]);
    end
    wr(8'h10, 16'hFFFF);
    rd(8'h10);
    chk(d, 0);
    chk(dcm_offset_low, v[0][6]);
    chk(input_sense_range_select, v[1][15:13]);
    chk(input_current_full_scale, v[3][6:0]);
    telem = {xs(), 16'(xs())};
    rd(8'h88);
    chk(d, telem.vin);
    rd(8'h89);
    chk(d, telem.iin);
    rd(8'h97);
    chk(d, telem.pin);
    chk(vid_input_power, telem.pin);
    {ps_single_phase, auto_dcm, aps_phase_count} = 6'h36;
    cyc(4);
    chk({dcm_mode, active_phases}, 5'h11);
    auto_dcm = 0;
    cyc(4);
    chk({dcm_mode, active_phases}, 5'h06);
    power = 1;
    cyc(60);
    tp = 10'h203;
    for (n = 0; n < 50 && bias_hs_on !== 1'b1; n++) cyc(1);
    tp = 10'h202;
    for (n = 0; n < 600 && bias_hs_on === 1'b1; n++) cyc(1);
    chk(n >= 115 * (v[2][7:6] + 1) - 2 && n <= 115 * (v[2][7:6] + 1) + 2, 1);
    chk(bias_ls_on, 1);
    cyc(20);
    chk(bias_hs_on, 0);
    tp = 10'h2C0;
    boot_zero_aux = 1;
    en_req = 1;
    for (n = 0; n < 200 && stage_detect_start !== 1'b1; n++) cyc(1);
    chk({stage_detect_start, vid_bus_active, core_power_good}, 3'h6);
    tp[5] = 1;
    cyc(10);
    chk({core_regulate, aux_regulate, ramp_slow}, 3'h5);
    tp[3] = 1;
    cyc(5);
    chk({core_power_good, aux_power_good}, 2'h2);
    set_voltage_aux = 1;
    cyc(1);
    set_voltage_aux = 0;
    tp[2] = 1;
    cyc(8);
    chk({aux_regulate, aux_power_good}, 2'h3);
    en_req = 0;
    cyc(20);
    en_req = 1;
    cyc(10);
    chk(core_regulate, 1);
    en_req = 0;
    cyc(50);
    en_req = 1;
    cyc(8);
    chk({stage_detect_start, core_power_good}, 0);
    for (n = 0; n < 100 && stage_detect_start !== 1'b1; n++) cyc(1);
    chk(stage_detect_start, 1);
    power = 0;
    cyc(120);
    tp[9] = 0;
    power = 1;
    for (n = 0; n < 200 && fault_flag !== 1'b1; n++) cyc(1);
    chk({fault_flag, stage_detect_start}, 2'h2);
    rd(8'hF9);
    chk(d, 16'h0001);
    test_done();
  end
endmodule
